/* logic/iad_datapath.sv */
// integer alu and shift datapath, one-cycle registered result
`timescale 1ns/100ps
`default_nettype none
`include "iad_params.svh"

module iad_datapath
	import iad_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire iad_req_t req,
	output iad_wb_t wb
);
	// ------------------------------------------------------------
	// operand preparation
	// ------------------------------------------------------------
	logic [63:0] opA;
	logic [63:0] opB;
	logic [63:0] imm15;
	logic [63:0] imm22;
	logic shAmtOk;
	logic [63:0] shlA;
	logic signed [63:0] sraVal;
	logic [63:0] ptrSum;
	logic [127:0] pairVal;
	logic [5:0] immShift;
	logic [6:0] immLen;
	logic [63:0] pullOut;
	logic [63:0] insertOut;
	logic fieldSigned;
	logic fieldZero;
	logic [5:0] fieldPos;
	logic [6:0] fieldLen;
	logic [63:0] fieldSrc;
	logic [63:0] resD;
	logic illegalD;
	iad_wb_t wb_d;
	iad_wb_t wb_q;

	// register zero reads as zero for IAD_ADDI22 only, whatever the decoder sent
	always_comb begin
		opA = (req.regSel1 == 6'd0 && req.op == IAD_ADDI22) ? 64'h0 : req.src1;
		opB = req.src2;
		imm15 = {{49{req.imm[14]}}, req.imm[14:0]};
		imm22 = {{42{req.imm[21]}}, req.imm[21:0]};
	end

	// shift counts outside 1..4 are refused
	assign shAmtOk = (req.shCount >= `IAD_SHL_MIN) && (req.shCount <= `IAD_SHL_MAX);
	assign shlA = opA << req.shCount;

	// signed shift kept apart: inside an unsigned select it would turn logical
	assign sraVal = $signed(opA) >>> opB[5:0];

	// immediate shifts as field ops reaching bit 63
	assign immShift = req.imm[5:0];
	assign immLen = 7'd64 - {1'b0, immShift};

	// field unit operand steering
	always_comb begin
		fieldSigned = 1'b0;
		fieldZero = 1'b0;
		fieldPos = req.fieldPos;
		fieldLen = req.fieldLen;
		fieldSrc = opA;
		case (req.op)
			IAD_EXTRS: fieldSigned = 1'b1;
			IAD_EXTRU: fieldSigned = 1'b0;
			IAD_DEP: begin
				// immediate source is all zeroes or all ones
				fieldSrc = req.useImm ? {64{req.imm[0]}} : opA;
			end
			IAD_DEPZ: begin
				fieldZero = 1'b1;
				fieldSrc = req.useImm ? {64{req.imm[0]}} : opA;
			end
			IAD_SHRI: begin
				fieldSigned = 1'b1;
				fieldPos = immShift;
				fieldLen = immLen;
			end
			IAD_SHLI: begin
				fieldZero = 1'b1;
				fieldPos = immShift;
				fieldLen = immLen;
			end
			default: begin
				fieldPos = req.fieldPos;
			end
		endcase
	end

	iad_field_unit uField (
		.srcVal(fieldSrc),
		.mergeVal(opB),
		.pos(fieldPos),
		.len(fieldLen),
		.signedPull(fieldSigned),
		.zeroMerge(fieldZero),
		.pullOut(pullOut),
		.insertOut(insertOut)
	);

	// ------------------------------------------------------------
	// result selection
	// ------------------------------------------------------------
	// both unit kinds take every op here; unit bit is not used
	always_comb begin
		resD = 64'h0;
		illegalD = 1'b0;
		ptrSum = 64'h0;
		pairVal = {opA, opB};
		case (req.op)
			// sums drop carry out, no flags
			IAD_ADD: resD = opA + (req.useImm ? req.imm : opB);
			IAD_ADD1: resD = opA + opB + 64'h1;
			IAD_SUB: resD = opA - opB;
			IAD_SUB1: resD = opA - opB - 64'h1;
			IAD_ADDI15: resD = imm15 + opB;
			IAD_SUBI15: resD = imm15 - opB;
			IAD_ADDI22: begin
				// only low four registers may feed the wide immediate
				resD = imm22 + opA;
				illegalD = (req.regSel1 > `IAD_IMM22_MAXREG);
			end
			IAD_SHLADD: begin
				resD = shlA + opB;
				illegalD = !shAmtOk;
			end
			IAD_AND: resD = (req.useImm ? req.imm : opA) & opB;
			IAD_OR: resD = (req.useImm ? req.imm : opA) | opB;
			IAD_XOR: resD = (req.useImm ? req.imm : opA) ^ opB;
			IAD_ANDCM: resD = (req.useImm ? req.imm : opA) & ~opB;
			IAD_ADDP: begin
				ptrSum = (req.useImm ? req.imm : opA) + opB;
				resD = {32'h0, ptrSum[31:0]};
				resD[`IAD_REGION_DST_HI:`IAD_REGION_DST_LO] =
					opB[`IAD_REGION_SRC_HI:`IAD_REGION_SRC_LO];
			end
			IAD_SHLADDP: begin
				// no immediate form exists
				ptrSum = shlA + opB;
				resD = {32'h0, ptrSum[31:0]};
				resD[`IAD_REGION_DST_HI:`IAD_REGION_DST_LO] =
					opB[`IAD_REGION_SRC_HI:`IAD_REGION_SRC_LO];
				illegalD = !shAmtOk || req.useImm;
			end
			IAD_SXT: begin
				case (req.extWidth)
					2'd0: resD = {{56{opA[7]}}, opA[7:0]};
					2'd1: resD = {{48{opA[15]}}, opA[15:0]};
					2'd2: resD = {{32{opA[31]}}, opA[31:0]};
					default: illegalD = 1'b1;
				endcase
			end
			IAD_ZXT: begin
				case (req.extWidth)
					2'd0: resD = {56'h0, opA[7:0]};
					2'd1: resD = {48'h0, opA[15:0]};
					2'd2: resD = {32'h0, opA[31:0]};
					default: illegalD = 1'b1;
				endcase
			end
			// amounts of 64 or more empty the register, or fill it with the sign bit for IAD_SHRS
			IAD_SHRS: resD = (opB > 64'd63) ? {64{opA[63]}} : sraVal;
			IAD_SHRU: resD = (opB > 64'd63) ? 64'h0 : opA >> opB[5:0];
			IAD_SHLV: resD = (opB > 64'd63) ? 64'h0 : opA << opB[5:0];
			IAD_EXTRS, IAD_EXTRU, IAD_SHRI: resD = pullOut;
			IAD_DEP, IAD_DEPZ, IAD_SHLI: resD = insertOut;
			IAD_SHRP: resD = pairVal[req.imm[5:0] +: 64];
			IAD_MOVL: resD = req.imm;
			default: illegalD = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// writeback register
	// ------------------------------------------------------------
	// refused ops still reply, flagged, so the decoder never waits
	always_comb begin
		wb_d.valid = req.valid;
		wb_d.illegal = req.valid & illegalD;
		wb_d.destReg = req.destReg;
		wb_d.data = illegalD ? 64'h0 : resD;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wb_q <= '0;
		end else begin
			wb_q <= wb_d;
		end
	end

	assign wb = wb_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_add_one: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADD1 |=> wb.data == $past(req.src1) + $past(req.src2) + 64'h1)
		else $error("add-one result wrong");
	a_sub_one: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SUB1 |=> wb.data == $past(req.src1) - $past(req.src2) - 64'h1)
		else $error("subtract-one result wrong");
	a_wide_imm_guard: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADDI22 && req.regSel1 > 6'd3 |=> wb.illegal)
		else $error("wide immediate not refused");
	a_ptr_region: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADDP |=> wb.data[63] == 1'b0 && wb.data[60:32] == 29'h0
		&& wb.data[62:61] == $past(req.src2[31:30]))
		else $error("pointer add region bits wrong");
	a_zero_widen: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ZXT && req.extWidth == 2'd0 |=> wb.data[63:8] == 56'h0)
		else $error("zero widen leaks upper bits");
	a_shr_signed: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHRS && req.src2 == 64'd63 |=> wb.data == {64{$past(req.src1[63])}})
		else $error("signed shift fill wrong");
	a_rotate_pair: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHRP && req.src1 == req.src2 && req.imm[5:0] == 6'd0
		|=> wb.data == $past(req.src2))
		else $error("funnel rotate wrong");
	a_long_const: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_MOVL |=> wb.valid && wb.data == $past(req.imm))
		else $error("long constant not written");
	a_reg_zero: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADDI22 && req.regSel1 == 6'd0
		|=> wb.data == {{42{$past(req.imm[21])}}, $past(req.imm[21:0])})
		else $error("short move not from zero register");

	// operand-level checks restated from the operation meaning
	a_imm15_add: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADDI15
		|=> wb.data == {{49{$past(req.imm[14])}}, $past(req.imm[14:0])} + $past(req.src2))
		else $error("short immediate add wrong");
	a_imm15_sub: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SUBI15
		|=> wb.data == {{49{$past(req.imm[14])}}, $past(req.imm[14:0])} - $past(req.src2))
		else $error("short immediate subtract wrong");
	a_shift_add: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHLADD && req.shCount >= 3'd1 && req.shCount <= 3'd4
		|=> wb.data == ($past(req.src1) << $past(req.shCount)) + $past(req.src2))
		else $error("shift-then-sum result wrong");
	a_shift_range: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHLADD && (req.shCount == 3'd0 || req.shCount > 3'd4)
		|=> wb.illegal && wb.data == 64'h0)
		else $error("shift count outside range not refused");
	a_logic_and: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_AND && !req.useImm
		|=> wb.data == ($past(req.src1) & $past(req.src2)))
		else $error("register and wrong");
	a_logic_imm: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_XOR && req.useImm
		|=> wb.data == ($past(req.imm) ^ $past(req.src2)))
		else $error("immediate xor wrong");
	a_and_inverse: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ANDCM
		|=> wb.data == (($past(req.useImm) ? $past(req.imm) : $past(req.src1)) & ~$past(req.src2)))
		else $error("and with inverse wrong");
	a_ptr_no_imm: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHLADDP && req.useImm
		|=> wb.illegal && wb.data == 64'h0)
		else $error("immediate shifted pointer add not refused");
	a_shr_zero: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHRU && req.src2 < 64'd64
		|=> wb.data == ($past(req.src1) >> $past(req.src2[5:0])))
		else $error("unsigned shift fill wrong");
	a_shl_var: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHLV && req.src2 < 64'd64
		|=> wb.data == ($past(req.src1) << $past(req.src2[5:0])))
		else $error("variable left shift wrong");
	a_pull_zero: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_EXTRU && req.fieldLen != 7'd0 && req.fieldLen < 7'd64
		|=> (wb.data & ~((64'h1 << $past(req.fieldLen)) - 64'h1)) == 64'h0)
		else $error("unsigned field pull leaks upper bits");
	a_insert_zero: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_DEPZ && req.fieldLen != 7'd0 && req.fieldLen < 7'd64
		|=> ((wb.data >> $past(req.fieldPos)) >> $past(req.fieldLen)) == 64'h0)
		else $error("zeroing insert leaks above field");
	a_imm_shr: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHRI |=> wb.data[63] == $past(req.src1[63])
		&& (wb.data & ({64{1'b1}} >> $past(req.imm[5:0]))) == ($past(req.src1) >> $past(req.imm[5:0])))
		else $error("immediate right shift wrong");
	a_imm_shl: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SHLI
		|=> wb.data == ($past(req.src1) << $past(req.imm[5:0])))
		else $error("immediate left shift wrong");
	a_wrap_sum: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_ADD && !req.useImm
		|=> wb.data == $past(req.src1) + $past(req.src2))
		else $error("plain add does not wrap");
	a_unit_same: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.op == IAD_SUB && req.unit == `IAD_UNIT_MEM
		|=> wb.data == $past(req.src1) - $past(req.src2))
		else $error("memory unit subtract wrong");
endmodule
`default_nettype wire

/* logic/iad_params.svh */
// constants for the integer alu shift datapath
`ifndef IAD_PARAMS_SVH
`define IAD_PARAMS_SVH
`define IAD_XLEN 64
`define IAD_HALF 32
`define IAD_IMM15_W 15
`define IAD_IMM22_W 22
`define IAD_IMM22_MAXREG 6'd3
`define IAD_SHL_MIN 3'd1
`define IAD_SHL_MAX 3'd4
`define IAD_REGION_SRC_HI 31
`define IAD_REGION_SRC_LO 30
`define IAD_REGION_DST_HI 62
`define IAD_REGION_DST_LO 61
`define IAD_UNIT_INT 1'b0
`define IAD_UNIT_MEM 1'b1
`endif

/* logic/iad_pkg.sv */
// types for the integer alu shift datapath
`include "iad_params.svh"
package iad_pkg;
	// operation codes, one-hot not needed: plain encoding
	typedef enum logic [4:0] {
		IAD_ADD = 5'h00,
		IAD_ADD1 = 5'h01,
		IAD_SUB = 5'h02,
		IAD_SUB1 = 5'h03,
		IAD_ADDI15 = 5'h04,
		IAD_SUBI15 = 5'h05,
		IAD_ADDI22 = 5'h06,
		IAD_SHLADD = 5'h07,
		IAD_AND = 5'h08,
		IAD_OR = 5'h09,
		IAD_XOR = 5'h0a,
		IAD_ANDCM = 5'h0b,
		IAD_ADDP = 5'h0c,
		IAD_SHLADDP = 5'h0d,
		IAD_SXT = 5'h0e,
		IAD_ZXT = 5'h0f,
		IAD_SHRS = 5'h10,
		IAD_SHRU = 5'h11,
		IAD_SHLV = 5'h12,
		IAD_EXTRS = 5'h13,
		IAD_EXTRU = 5'h14,
		IAD_DEP = 5'h15,
		IAD_DEPZ = 5'h16,
		IAD_SHRP = 5'h17,
		IAD_SHRI = 5'h18,
		IAD_SHLI = 5'h19,
		IAD_MOVL = 5'h1a
	} iad_op_t;

	// issue bundle from the decoder
	typedef struct packed {
		logic valid;
		logic unit;
		iad_op_t op;
		logic [5:0] regSel1;
		logic useImm;
		logic [63:0] src1;
		logic [63:0] src2;
		logic [63:0] imm;
		logic [2:0] shCount;
		logic [1:0] extWidth;
		logic [5:0] fieldPos;
		logic [6:0] fieldLen;
		logic [5:0] destReg;
	} iad_req_t;

	// writeback to the general_register file
	typedef struct packed {
		logic valid;
		logic illegal;
		logic [5:0] destReg;
		logic [63:0] data;
	} iad_wb_t;
endpackage

/* logic/iad_field_unit.sv */
// field pull and field insert helper
`timescale 1ns/100ps
`default_nettype none
module iad_field_unit
	import iad_pkg::*;
(
	input wire logic [63:0] srcVal,
	input wire logic [63:0] mergeVal,
	input wire logic [5:0] pos,
	input wire logic [6:0] len,
	input wire logic signedPull,
	input wire logic zeroMerge,
	output logic [63:0] pullOut,
	output logic [63:0] insertOut
);
	logic [63:0] lenMask;
	logic [63:0] shifted;
	logic [63:0] placeMask;
	logic signBit;
	logic [6:0] topIdx;

	// masks from length, field clipped at bit 63
	always_comb begin
		lenMask = (len >= 7'd64) ? '1 : ((64'h1 << len) - 64'h1);
		shifted = srcVal >> pos;
		topIdx = (len == 7'd0) ? 7'd0 : len - 7'd1;
		signBit = shifted[topIdx[5:0]];
		// field pull keeps len bits, fill with sign or zero
		pullOut = shifted & lenMask;
		if (signedPull && len != 7'd0 && signBit) begin
			pullOut = pullOut | ~lenMask;
		end
		placeMask = lenMask << pos;
		insertOut = ((srcVal << pos) & placeMask) | (zeroMerge ? 64'h0 : (mergeVal & ~placeMask));
	end
endmodule
`default_nettype wire

/* test/iad_decoder_model.sv */
// decoder model feeding the datapath, operand values supplied by the bench
`timescale 1ns/100ps
`default_nettype none
module iad_decoder_model
	import iad_pkg::*;
(
	input wire logic clk,
	output var iad_req_t req,
	input wire iad_wb_t wb
);
	// requests change at the falling edge, so the rising edge sees them settled
	task automatic send(input iad_req_t r, output iad_wb_t got);
		@(negedge clk);
		req = r;
		@(posedge clk);
		#1 got = wb;
	endtask

	// quiet bus until the first request
	initial begin
		req = '0;
	end
endmodule
`default_nettype wire

/* test/integer_alu_shift_datapath_tb.sv */
// self-checking bench for the integer alu shift datapath
`timescale 1ns/100ps
`default_nettype none
module integer_alu_shift_datapath_tb
	import iad_pkg::*;
;
	localparam logic [63:0] ONES = '1;
	localparam logic [63:0] TOP = 64'h8000_0000_0000_0000;
	logic clk;
	logic nrst;
	iad_req_t req;
	iad_wb_t wb;
	iad_req_t r;
	iad_wb_t got;
	int badCount;
	int compares;
	logic [2:0] sc;
	logic [1:0] w;
	logic [5:0] rs;
	logic ui;
	logic un;
	logic [5:0] fp;
	logic [6:0] fl;

	iad_datapath u_iad_datapath (
		.clk(clk),
		.nrst(nrst),
		.req(req),
		.wb(wb)
	);

	iad_decoder_model u_iad_decoder_model (
		.clk(clk),
		.req(req),
		.wb(wb)
	);

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic endOfTest();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [71:0] e, input logic [71:0] g);
		compares++;
		if (g !== e) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// field defaults restored after every request so tweaks never leak
	task automatic dflt();
		un = 1'b0;
		rs = 6'h01;
		ui = 1'b0;
		sc = 3'h1;
		w = 2'h0;
		fp = 6'h00;
		fl = 7'h00;
	endtask

	// one request, answer compared whole: illegal, valid, destination, data
	task automatic run(input iad_op_t op, input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] i, input logic [63:0] e, input logic ill);
		r = '0;
		r.valid = 1'b1;
		r.op = op;
		r.unit = un;
		r.regSel1 = rs;
		r.useImm = ui;
		r.src1 = a;
		r.src2 = b;
		r.imm = i;
		r.shCount = sc;
		r.extWidth = w;
		r.fieldPos = fp;
		r.fieldLen = fl;
		r.destReg = {1'b0, op};
		u_iad_decoder_model.send(r, got);
		check(op.name(), {ill, 1'b1, r.destReg, e},
			{got.illegal, got.valid, got.destReg, got.data});
		dflt();
	endtask

	// ----------------------------------------
	// scenarios, issued back to back except around the reset in tReset
	// ----------------------------------------
	task automatic tArith();
		run(IAD_ADD1, 64'h5, 64'h7, 64'h0, 64'hd, 1'b0);
		run(IAD_ADD1, ONES, 64'h0, 64'h0, 64'h0, 1'b0);
		run(IAD_ADD, ONES, 64'h2, 64'h0, 64'h1, 1'b0);
		run(IAD_SUB1, 64'ha, 64'h3, 64'h0, 64'h6, 1'b0);
		un = 1'b1;
		run(IAD_SUB, 64'h0, 64'h1, 64'h0, ONES, 1'b0);
		run(IAD_ADDI15, ONES, 64'h14, 64'h1234_0000_0000_7fff, 64'h13, 1'b0);
		run(IAD_SUBI15, ONES, 64'h5, 64'ha, 64'h5, 1'b0);
		rs = 6'h03;
		run(IAD_ADDI22, 64'h9, 64'h9, 64'h3f_ffff, 64'h8, 1'b0);
		rs = 6'h04;
		run(IAD_ADDI22, 64'h9, 64'h9, 64'h3f_ffff, 64'h0, 1'b1);
		rs = 6'h00;
		run(IAD_ADDI22, 64'h9, 64'h9, 64'h1f_ffff, 64'h1f_ffff, 1'b0);
		sc = 3'h4;
		run(IAD_SHLADD, 64'h3, 64'h2, 64'h0, 64'h32, 1'b0);
		sc = 3'h0;
		run(IAD_SHLADD, 64'h3, 64'h2, 64'h0, 64'h0, 1'b1);
		sc = 3'h5;
		run(IAD_SHLADD, 64'h3, 64'h2, 64'h0, 64'h0, 1'b1);
		$display("arithmetic test done");
	endtask

	task automatic tLogic();
		run(IAD_AND, 64'hf0f0, 64'hff00, 64'h0, 64'hf000, 1'b0);
		run(IAD_OR, 64'hf0f0, 64'hff00, 64'h0, 64'hfff0, 1'b0);
		run(IAD_XOR, 64'hf0f0, 64'hff00, 64'h0, 64'h0ff0, 1'b0);
		run(IAD_ANDCM, 64'hf0f0, 64'hff00, 64'h0, 64'h00f0, 1'b0);
		ui = 1'b1;
		run(IAD_AND, ONES, 64'hff00, 64'h0ff0, 64'h0f00, 1'b0);
		ui = 1'b1;
		run(IAD_XOR, ONES, 64'hff00, 64'h0ff0, 64'hf0f0, 1'b0);
		ui = 1'b1;
		run(IAD_ANDCM, ONES, 64'hff00, 64'h0ff0, 64'h00f0, 1'b0);
		$display("logic test done");
	endtask

	task automatic tPtr();
		run(IAD_ADDP, 64'hffff_ffff_8000_0001, 64'hc000_0002, 64'h0,
			64'h6000_0000_4000_0003, 1'b0);
		ui = 1'b1;
		run(IAD_ADDP, ONES, 64'h4000_0000, 64'h5, 64'h2000_0000_4000_0005, 1'b0);
		sc = 3'h2;
		run(IAD_SHLADDP, 64'h1, 64'h4000_0000, 64'h0, 64'h2000_0000_4000_0004, 1'b0);
		ui = 1'b1;
		run(IAD_SHLADDP, 64'h1, 64'h4000_0000, 64'h0, 64'h0, 1'b1);
		run(IAD_SXT, 64'h8080_8080, 64'h8080_8080, 64'h0, ONES << 8 | 64'h80, 1'b0);
		run(IAD_ZXT, 64'h8080_8080, 64'h8080_8080, 64'h0, 64'h80, 1'b0);
		w = 2'h1;
		run(IAD_SXT, 64'h8080_8080, 64'h8080_8080, 64'h0, ONES << 16 | 64'h8080, 1'b0);
		w = 2'h2;
		run(IAD_SXT, 64'h8080_8080, 64'h8080_8080, 64'h0, ONES << 32 | 64'h8080_8080, 1'b0);
		w = 2'h2;
		run(IAD_ZXT, 64'h8080_8080, 64'h8080_8080, 64'h0, 64'h8080_8080, 1'b0);
		w = 2'h3;
		run(IAD_ZXT, 64'h8080_8080, 64'h8080_8080, 64'h0, 64'h0, 1'b1);
		$display("pointer and widen test done");
	endtask

	task automatic tShift();
		run(IAD_SHRS, TOP, 64'h4, 64'h0, 64'hf800_0000_0000_0000, 1'b0);
		run(IAD_SHRS, TOP, 64'h3f, 64'h0, ONES, 1'b0);
		run(IAD_SHRU, TOP, 64'h4, 64'h0, 64'h0800_0000_0000_0000, 1'b0);
		run(IAD_SHRU, TOP, 64'h40, 64'h0, 64'h0, 1'b0);
		run(IAD_SHLV, 64'h1, 64'h3f, 64'h0, TOP, 1'b0);
		fp = 6'h08;
		fl = 7'h04;
		run(IAD_EXTRS, 64'hf00, 64'h0, 64'h0, ONES, 1'b0);
		fp = 6'h08;
		fl = 7'h04;
		run(IAD_EXTRU, 64'hf00, 64'h0, 64'h0, 64'hf, 1'b0);
		fp = 6'h04;
		fl = 7'h03;
		run(IAD_DEP, 64'h5, ONES, 64'h0, ONES ^ 64'h20, 1'b0);
		fp = 6'h04;
		fl = 7'h03;
		run(IAD_DEPZ, 64'h5, ONES, 64'h0, 64'h50, 1'b0);
		fp = 6'h04;
		fl = 7'h03;
		ui = 1'b1;
		run(IAD_DEPZ, 64'h0, ONES, 64'h1, 64'h70, 1'b0);
		run(IAD_SHRP, 64'h1, 64'h0, 64'h4, 64'h1000_0000_0000_0000, 1'b0);
		run(IAD_SHRP, 64'h1, 64'h1, 64'h1, TOP, 1'b0);
		run(IAD_SHRP, 64'h5, 64'h5, 64'h0, 64'h5, 1'b0);
		run(IAD_SHRI, TOP, 64'h0, 64'h8, 64'hff80_0000_0000_0000, 1'b0);
		run(IAD_SHLI, 64'h3, 64'h0, 64'h3e, 64'hc000_0000_0000_0000, 1'b0);
		run(IAD_MOVL, 64'h0, 64'h0, 64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef, 1'b0);
		$display("shift and field test done");
	endtask

	// an idle cycle, then a reset landing on a live request
	task automatic tReset();
		r.valid = 1'b0;
		u_iad_decoder_model.send(r, got);
		check("idle", 72'h0, {71'h0, got.valid});
		r.valid = 1'b1;
		@(negedge clk);
		nrst = 1'b0;
		u_iad_decoder_model.send(r, got);
		check("reset", 72'h0, {got.illegal, got.valid, got.destReg, got.data});
		@(negedge clk);
		nrst = 1'b1;
		// first request after release must come back whole
		run(IAD_MOVL, 64'h0, 64'h0, 64'hfedc_ba98_7654_3210, 64'hfedc_ba98_7654_3210, 1'b0);
		$display("reset test done");
	endtask

	// clock at 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// watchdog fires after 2000 cycles: the whole run needs well under 200 cycles
	initial begin
		#200000;
		badCount++;
		endOfTest();
	end

	// main sequence
	initial begin
		nrst = 1'b0;
		badCount = 0;
		compares = 0;
		dflt();
		repeat (2) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		@(posedge clk);
		#1 check("after reset", 72'h0, {wb.illegal, wb.valid, wb.destReg, wb.data});
		tArith();
		tLogic();
		tPtr();
		tShift();
		tReset();
		endOfTest();
	end
endmodule
`default_nettype wire
